// file: shared/program_security_map.vh
/*
  register offsets, field positions, keys and timing for the program security block.
  assumes inclusion by bare name from design and bench files.
*/
`ifndef PROGRAM_SECURITY_MAP_VH
`define PROGRAM_SECURITY_MAP_VH

// sfr space (8-bit address)
`define FLASH_CONTROL_OFS      8'hB2
// xram-mapped space (16-bit address)
`define FUSE_BURN_TRIGGER_OFS  16'hFFD1
`define FUSE_UNLOCK_KEY_OFS    16'hFFD2
`define SECURITY_FUSE_OFS      16'hFFD7

// flash_control_reg fields
`define FC_WRITE_EN_BIT        0
`define FC_MASS_EN_BIT         1
`define FC_LOCK_BIT            6
// security_fuse_reg fields
`define SF_MODE1_BIT           0
`define SF_MODE0_BIT           1
`define SF_PIN_BIT             5
`define SF_PROG_EN_BIT         7

// keys
`define KEY_ARM                8'h54
`define KEY_SEL_MODE0          8'h81
`define KEY_SEL_MODE1          8'h82
`define KEY_BURN               8'hA6
`define KEY_CLEAR              8'h00

// reset values
`define FLASH_CONTROL_RST      8'h00
`define SECURITY_FUSE_RST      8'h00

// debug port commands
`define DBG_CMD_READ_FLASH     3'h0
`define DBG_CMD_READ_XRAM      3'h1
`define DBG_CMD_WRITE_FLASH    3'h2
`define DBG_CMD_PAGE_ERASE     3'h3
`define DBG_CMD_BULK_ERASE     3'h4
`define DBG_CMD_CORE_CTRL      3'h5

// timing
`define CLK_FREQ_MHZ           50
`define BURN_TIME_US           500
`define BURN_CYCLES            (`BURN_TIME_US * `CLK_FREQ_MHZ)

`endif

// file: rtl/fuse_burn_driver.v
/*
  fuse burn sequencer: arm key, fuse select, burn pulse with time limit.
  assumes key writes arrive as one-cycle strobes from the register decoder.
*/
`timescale 1ns/1ps
`include "program_security_map.vh"

module fuse_burn_driver #(
  parameter BURN_CYCLES = `BURN_CYCLES
) (
  input  wire       i_clk,
  input  wire       i_resetn,
  input  wire       i_unlock_we,
  input  wire       i_trigger_we,
  input  wire [7:0] i_wdata,
  input  wire       i_prog_en,
  input  wire       i_sec_pin,
  output reg  [1:0] o_burn,
  output wire       o_busy
);

  localparam ST_IDLE  = 2'd0;
  localparam ST_ARMED = 2'd1;
  localparam ST_SEL   = 2'd2;
  localparam ST_BURN  = 2'd3;

  reg [1:0]  state_reg;
  reg [1:0]  state_next;
  reg        sel1_reg;
  reg        sel1_next;
  reg [31:0] timer_reg;
  reg [31:0] timer_next;

  assign o_busy = (state_reg == ST_BURN);

  always @* begin
    state_next = state_reg;
    sel1_next  = sel1_reg;
    timer_next = timer_reg;
    case (state_reg)
      ST_IDLE: begin
        if (i_unlock_we && i_wdata == `KEY_ARM) begin
          state_next = ST_ARMED;
        end
      end
      ST_ARMED: begin
        if (i_unlock_we) begin
          if (i_wdata == `KEY_SEL_MODE0 || i_wdata == `KEY_SEL_MODE1) begin
            state_next = ST_SEL;
            sel1_next  = (i_wdata == `KEY_SEL_MODE1);
          end else if (i_wdata != `KEY_ARM) begin
            state_next = ST_IDLE;
          end
        end
      end
      ST_SEL: begin
        if (i_unlock_we && i_wdata != `KEY_SEL_MODE0 && i_wdata != `KEY_SEL_MODE1) begin
          state_next = ST_IDLE; // any non-select key aborts; a second select key is ignored
        end else if (i_trigger_we && i_wdata == `KEY_BURN && i_prog_en) begin
          state_next = ST_BURN;
          timer_next = 32'h00000000;
        end
      end
      default: begin
        timer_next = timer_reg + 32'h00000001;
        if (i_trigger_we && i_wdata != `KEY_BURN) begin
          state_next = ST_IDLE;
        end else if (i_unlock_we && i_wdata == `KEY_CLEAR) begin
          state_next = ST_IDLE;
        end else if (timer_reg >= BURN_CYCLES - 1) begin
          state_next = ST_SEL;
        end
      end
    endcase
  end

  always @(posedge i_clk) begin
    if (!i_resetn) begin
      state_reg <= ST_IDLE;
      sel1_reg  <= 1'b0;
      timer_reg <= 32'h00000000;
      o_burn    <= 2'b00;
    end else begin
      state_reg <= state_next;
      sel1_reg  <= sel1_next;
      timer_reg <= timer_next;
      o_burn[0] <= (state_next == ST_BURN) && !sel1_next;
      // mode-1 burn needs the pin held high the whole time
      o_burn[1] <= (state_next == ST_BURN) && sel1_next && i_sec_pin;
    end
  end

endmodule

// file: rtl/program_security_fuse_ctrl.v
/*
  program security: lock bit, security fuses, debug port and flash access gating.
  assumes sfr and xram register strobes last one cycle; fuse sense inputs
  reflect the physical fuse cells; all inputs synchronous to I_SYS_CLK.
*/
`timescale 1ns/1ps
`include "program_security_map.vh"

// Contract
// - lock bit clears on reset; software may set it, clearing writes ignored.
// - with protection active, debug port may only bulk erase.
// - with protection active, debug reads of flash or xram are refused.
// - with protection active, page zero erase refused from mpu and debug port.
// - with protection active, page zero byte writes refused from both sides.
// - any global flash erase also clears xram, protected or not.
// - protection leaves only via global erase then full reset; here any reset alone clears the lock bit and ends it.
// - lock bit protects only when mode-0 fuse, bit 1, is blown.
// - blown fuses stay in force; no write or reset overrides them.
// - mode-1 fuse disables the debug port at once and forever.
// - mode-1 fuse state is sampled during reset, before boot starts.
// - security register bit 5 reads back the security pin level.
// - burn key blows the fuse; firmware later writes zero to both registers.
// - security register bit 7 set permits fuse programming.
// - any non-burn value written to the trigger stops the burn.
module program_security_fuse_ctrl #(
  parameter BURN_CYCLES = `BURN_CYCLES
) (
  input  wire        I_SYS_CLK,
  input  wire        I_RESETN,
  input  wire [7:0]  I_SFR_ADDR,
  input  wire        I_SFR_WE,
  input  wire        I_SFR_RE,
  input  wire [7:0]  I_SFR_WDATA,
  output reg  [7:0]  O_SFR_RDATA,
  input  wire [15:0] I_XADDR,
  input  wire        I_XWE,
  input  wire        I_XRE,
  input  wire [7:0]  I_XWDATA,
  output reg  [7:0]  O_XRDATA,
  input  wire        I_SEC_PIN,
  input  wire [1:0]  I_FUSE_SENSE,
  output wire [1:0]  O_FUSE_BURN,
  output wire        O_BURN_BUSY,
  input  wire        I_DBG_REQ,
  input  wire [2:0]  I_DBG_CMD,
  input  wire [6:0]  I_DBG_PAGE,
  output wire        O_DBG_GRANT,
  output wire        O_DBG_REFUSE,
  output wire        O_DBG_ENABLED,
  input  wire        I_MPU_PAGE_ERASE,
  input  wire        I_MPU_FLASH_WR,
  input  wire        I_MPU_MASS_ERASE,
  input  wire [6:0]  I_MPU_PAGE,
  output wire        O_MPU_GRANT,
  output wire        O_MPU_REFUSE,
  input  wire        I_FLASH_BYTE_DONE,
  output wire        O_FLASH_WRITE_SEL,
  output reg         O_XRAM_CLEAR,
  output wire        O_PROTECT_ACTIVE
);

  reg  lock_reg;
  reg  write_en_reg;
  reg  mass_en_reg;
  reg  prog_en_reg;
  reg  mode0_fuse_reg;
  reg  mode1_fuse_reg;

  localparam [7:0] FC_RST = `FLASH_CONTROL_RST;
  localparam [7:0] SF_RST = `SECURITY_FUSE_RST;

  wire sfr_fc_we  = I_SFR_WE && (I_SFR_ADDR == `FLASH_CONTROL_OFS);
  wire trig_we    = I_XWE && (I_XADDR == `FUSE_BURN_TRIGGER_OFS);
  wire unlock_we  = I_XWE && (I_XADDR == `FUSE_UNLOCK_KEY_OFS);
  wire sec_we     = I_XWE && (I_XADDR == `SECURITY_FUSE_OFS);

  wire protect    = lock_reg && mode0_fuse_reg;
  wire dbg_on     = !mode1_fuse_reg && !I_FUSE_SENSE[1];

  // debug port gating
  wire dbg_bulk   = (I_DBG_CMD == `DBG_CMD_BULK_ERASE);
  wire dbg_read   = (I_DBG_CMD == `DBG_CMD_READ_FLASH) || (I_DBG_CMD == `DBG_CMD_READ_XRAM);
  wire dbg_page0  = (I_DBG_PAGE == 7'h00) &&
                    ((I_DBG_CMD == `DBG_CMD_PAGE_ERASE) || (I_DBG_CMD == `DBG_CMD_WRITE_FLASH));
  wire dbg_block  = !dbg_on ||
                    (protect && !dbg_bulk) ||
                    (protect && dbg_read) ||
                    (protect && dbg_page0);

  assign O_DBG_GRANT   = I_DBG_REQ && !dbg_block;
  assign O_DBG_REFUSE  = I_DBG_REQ && dbg_block;
  assign O_DBG_ENABLED = dbg_on;

  // mpu flash gating
  wire mpu_req    = I_MPU_PAGE_ERASE || I_MPU_FLASH_WR || I_MPU_MASS_ERASE;
  wire mpu_page0  = (I_MPU_PAGE == 7'h00) && (I_MPU_PAGE_ERASE || I_MPU_FLASH_WR);
  wire mpu_block  = (protect && mpu_page0) ||
                    (I_MPU_FLASH_WR && !write_en_reg) ||
                    (I_MPU_MASS_ERASE && (!mass_en_reg || !dbg_on));

  assign O_MPU_GRANT  = mpu_req && !mpu_block;
  assign O_MPU_REFUSE = mpu_req && mpu_block;

  wire global_erase = (O_DBG_GRANT && dbg_bulk) || (O_MPU_GRANT && I_MPU_MASS_ERASE);

  assign O_FLASH_WRITE_SEL = write_en_reg;
  assign O_PROTECT_ACTIVE  = protect;

  // fuse state: sampled during reset, sticky afterwards
  always @(posedge I_SYS_CLK) begin
    if (!I_RESETN) begin
      mode0_fuse_reg <= I_FUSE_SENSE[0];
      mode1_fuse_reg <= I_FUSE_SENSE[1];
    end else begin
      mode0_fuse_reg <= mode0_fuse_reg | I_FUSE_SENSE[0];
      mode1_fuse_reg <= mode1_fuse_reg | I_FUSE_SENSE[1];
    end
  end

  // flash control and security register writes
  always @(posedge I_SYS_CLK) begin
    if (!I_RESETN) begin
      lock_reg     <= FC_RST[`FC_LOCK_BIT];
      write_en_reg <= FC_RST[`FC_WRITE_EN_BIT];
      mass_en_reg  <= FC_RST[`FC_MASS_EN_BIT];
      prog_en_reg  <= SF_RST[`SF_PROG_EN_BIT];
      O_XRAM_CLEAR <= 1'b0;
    end else begin
      O_XRAM_CLEAR <= global_erase;
      if (sfr_fc_we && I_SFR_WDATA[`FC_LOCK_BIT]) begin
        lock_reg <= 1'b1; // set only, zero ignored
      end
      if (sfr_fc_we) begin
        write_en_reg <= I_SFR_WDATA[`FC_WRITE_EN_BIT];
      end else if (I_FLASH_BYTE_DONE) begin
        write_en_reg <= 1'b0;
      end
      if (sfr_fc_we) begin
        mass_en_reg <= I_SFR_WDATA[`FC_MASS_EN_BIT];
      end else if (O_MPU_GRANT && I_MPU_MASS_ERASE) begin
        mass_en_reg <= 1'b0;
      end
      if (sec_we) begin
        prog_en_reg <= I_XWDATA[`SF_PROG_EN_BIT];
      end
    end
  end

  // register reads
  always @(posedge I_SYS_CLK) begin
    if (!I_RESETN) begin
      O_SFR_RDATA <= 8'h00;
      O_XRDATA    <= 8'h00;
    end else begin
      if (I_SFR_RE && I_SFR_ADDR == `FLASH_CONTROL_OFS) begin
        O_SFR_RDATA <= {1'b0, lock_reg, 5'b00000, write_en_reg};
      end else begin
        O_SFR_RDATA <= 8'h00;
      end
      if (I_XRE && I_XADDR == `SECURITY_FUSE_OFS) begin
        O_XRDATA <= {prog_en_reg, 1'b0, I_SEC_PIN, 3'b000,
                     mode0_fuse_reg, mode1_fuse_reg};
      end else begin
        O_XRDATA <= 8'h00;
      end
    end
  end

  fuse_burn_driver #(
    .BURN_CYCLES (BURN_CYCLES)
  ) u_burn (
    .i_clk        (I_SYS_CLK),
    .i_resetn     (I_RESETN),
    .i_unlock_we  (unlock_we),
    .i_trigger_we (trig_we),
    .i_wdata      (I_XWDATA),
    .i_prog_en    (prog_en_reg),
    .i_sec_pin    (I_SEC_PIN),
    .o_burn       (O_FUSE_BURN),
    .o_busy       (O_BURN_BUSY)
  );

endmodule

// file: verif/psf_asserts.sv
/* port assertions for the program security block.
   assumes binding onto program_security_fuse_ctrl. */
`timescale 1ns/1ps
`include "program_security_map.vh"
module psf_asserts #(
  parameter BURN_CYCLES = 20
) (
  input logic        I_SYS_CLK,
  input logic        I_RESETN,
  input logic [15:0] I_XADDR,
  input logic        I_XWE,
  input logic        I_XRE,
  input logic [7:0]  I_XWDATA,
  input logic [7:0]  O_XRDATA,
  input logic        I_SEC_PIN,
  input logic [1:0]  O_FUSE_BURN,
  input logic        I_DBG_REQ,
  input logic [2:0]  I_DBG_CMD,
  input logic        O_DBG_GRANT,
  input logic        O_DBG_REFUSE,
  input logic        O_DBG_ENABLED,
  input logic        I_MPU_PAGE_ERASE,
  input logic        I_MPU_FLASH_WR,
  input logic        I_MPU_MASS_ERASE,
  input logic        O_MPU_GRANT,
  input logic [6:0]  I_MPU_PAGE,
  input logic        O_MPU_REFUSE,
  input logic        O_XRAM_CLEAR,
  input logic        O_PROTECT_ACTIVE
);
  default clocking @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RESETN);
  logic [15:0] cnt;
  logic        prog_seen;
  // programming enable as last written
  always @(posedge I_SYS_CLK)
    prog_seen <= !I_RESETN ? 1'b0 :
                 (I_XWE && I_XADDR == `SECURITY_FUSE_OFS) ? I_XWDATA[`SF_PROG_EN_BIT] : prog_seen;
  // cycles the burn drive has stood
  always @(posedge I_SYS_CLK)
    cnt <= (!I_RESETN || O_FUSE_BURN == 2'h0) ? 16'h0000 : cnt + 16'h0001;
  sequence s_xw(a, d);
    I_XWE && I_XADDR == a && I_XWDATA == d;
  endsequence
  a_dbg_one: assert property (I_DBG_REQ |-> O_DBG_GRANT ^ O_DBG_REFUSE)
    else $error("debug answer not exactly one");
  a_lock_bulk: assert property (O_PROTECT_ACTIVE && I_DBG_REQ
    && I_DBG_CMD != `DBG_CMD_BULK_ERASE |-> O_DBG_REFUSE) else $error("debug op not refused");
  a_lock_read: assert property (O_PROTECT_ACTIVE && I_DBG_REQ
    && I_DBG_CMD <= `DBG_CMD_READ_XRAM |-> O_DBG_REFUSE) else $error("debug read allowed");
  a_page0_erase: assert property (O_PROTECT_ACTIVE && I_MPU_PAGE_ERASE
    && I_MPU_PAGE == 7'h00 |-> O_MPU_REFUSE) else $error("page zero erase allowed");
  a_page0_write: assert property (O_PROTECT_ACTIVE && I_MPU_FLASH_WR
    && I_MPU_PAGE == 7'h00 |-> O_MPU_REFUSE) else $error("page zero write allowed");
  a_erase_clear: assert property (I_DBG_REQ && I_DBG_CMD == `DBG_CMD_BULK_ERASE
    && O_DBG_GRANT |=> O_XRAM_CLEAR ##1 !O_XRAM_CLEAR) else $error("xram clear missing");
  a_mass_clear: assert property (I_MPU_MASS_ERASE && O_MPU_GRANT |=> O_XRAM_CLEAR)
    else $error("xram clear missing after mass erase");
  a_lock_sticky: assert property (O_PROTECT_ACTIVE |=> O_PROTECT_ACTIVE)
    else $error("protection dropped");
  a_mode1_off: assert property (!O_DBG_ENABLED && I_DBG_REQ |-> O_DBG_REFUSE)
    else $error("debug active in mode 1");
  a_burn_start: assert property (s_xw(`FUSE_UNLOCK_KEY_OFS, `KEY_ARM) ##[1:4]
    s_xw(`FUSE_UNLOCK_KEY_OFS, `KEY_SEL_MODE0) ##[1:4]
    s_xw(`FUSE_BURN_TRIGGER_OFS, `KEY_BURN) ##0 prog_seen |-> ##[1:2] O_FUSE_BURN == 2'h1)
    else $error("burn did not start");
  a_burn_stop: assert property (I_XWE && I_XADDR == `FUSE_BURN_TRIGGER_OFS
    && I_XWDATA != `KEY_BURN |-> ##[1:2] O_FUSE_BURN == 2'h0) else $error("burn not stopped");
  a_pin_read: assert property (I_XRE && I_XADDR == `SECURITY_FUSE_OFS
    |=> O_XRDATA[5] == $past(I_SEC_PIN)) else $error("pin level misread");
  a_burn_limit: assert property (cnt <= BURN_CYCLES + 1)
    else $error("burn ran too long");
endmodule
bind program_security_fuse_ctrl psf_asserts #(.BURN_CYCLES(BURN_CYCLES)) i_psf_asserts (.*);

// file: verif/dbg_port_model.sv
/* debug port and security pin on the far side.
   assumes the bench calls access and set_pin. */
`timescale 1ns/1ps
module dbg_port_model (
  input  wire       i_clk,
  input  wire       i_grant,
  input  wire       i_refuse,
  output reg        o_req,
  output reg  [2:0] o_cmd,
  output reg  [6:0] o_page,
  output reg        o_sec_pin
);
  initial begin
    o_req = 1'b0;
    o_cmd = 3'h7;
    o_page = 7'h55;
    o_sec_pin = 1'b0; // pull-down level
  end
  task access(input [2:0] c, input [6:0] p, output g, output r);
    begin
      @(negedge i_clk);
      o_req = 1'b1;
      o_cmd = c;
      o_page = p;
      #1;
      g = i_grant;
      r = i_refuse;
      @(posedge i_clk);
      @(negedge i_clk);
      o_req = 1'b0;
      o_cmd = ~c;
      o_page = ~p;
    end
  endtask
  task set_pin(input v);
    begin
      @(negedge i_clk);
      o_sec_pin = v;
    end
  endtask
endmodule

// file: verif/program_security_fuse_ctrl_tb.sv
/* self-checking bench for the program security block.
   assumes the shared map header and the debug port model. */
`timescale 1ns/1ps
`include "program_security_map.vh"
module program_security_fuse_ctrl_tb;
  reg I_SYS_CLK = 0, I_RESETN = 0, I_SFR_WE = 0, I_SFR_RE = 0, I_XWE = 0, I_XRE = 0;
  reg I_MPU_PAGE_ERASE = 0, I_MPU_FLASH_WR = 0, I_MPU_MASS_ERASE = 0, I_FLASH_BYTE_DONE = 0;
  reg [7:0] I_SFR_ADDR = 0, I_SFR_WDATA = 0, I_XWDATA = 0;
  reg [15:0] I_XADDR = 0;
  reg [1:0] I_FUSE_SENSE = 0;
  reg [6:0] I_MPU_PAGE = 0;
  wire [7:0] O_SFR_RDATA, O_XRDATA;
  wire [1:0] O_FUSE_BURN;
  wire O_BURN_BUSY, O_DBG_GRANT, O_DBG_REFUSE, O_DBG_ENABLED, O_MPU_GRANT, O_MPU_REFUSE;
  wire O_FLASH_WRITE_SEL, O_XRAM_CLEAR, O_PROTECT_ACTIVE, I_DBG_REQ, I_SEC_PIN;
  wire [2:0] I_DBG_CMD;
  wire [6:0] I_DBG_PAGE;
  integer miscompares = 0, n_tests = 0, seed = 13, cyc = 0, lock = 0, r, k;
  reg [7:0] v;
  reg pin;
  program_security_fuse_ctrl #(.BURN_CYCLES(20)) i_program_security_fuse_ctrl (.*);
  dbg_port_model i_dbg_port_model (.i_clk(I_SYS_CLK), .i_grant(O_DBG_GRANT),
    .i_refuse(O_DBG_REFUSE), .o_req(I_DBG_REQ), .o_cmd(I_DBG_CMD), .o_page(I_DBG_PAGE),
    .o_sec_pin(I_SEC_PIN));
  initial forever #10 I_SYS_CLK = ~I_SYS_CLK;
  always @(posedge I_SYS_CLK) begin
    cyc = cyc + 1;
    if (cyc > 3000) begin
      miscompares = miscompares + 1;
      final_report;
    end
  end
  task chk(input [7:0] seen, input [7:0] exp);
    begin
      n_tests = n_tests + 1;
      if (seen !== exp) begin
        miscompares = miscompares + 1;
        $display("ERROR %0t: saw %h want %h", $time, seen, exp);
      end
    end
  endtask
  task final_report;
    begin
      $display("mismatches %0d of %0d checks", miscompares, n_tests);
      if (miscompares == 0 && n_tests > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  task acc(input x, input w, input [15:0] a, input [7:0] d);
    begin
      @(negedge I_SYS_CLK);
      I_XWE = x & w;
      I_SFR_WE = !x & w;
      I_XRE = x & !w;
      I_SFR_RE = !x & !w;
      I_XADDR = a;
      I_SFR_ADDR = a[7:0];
      I_XWDATA = d;
      I_SFR_WDATA = d;
      @(negedge I_SYS_CLK);
      {I_XWE, I_SFR_WE, I_XRE, I_SFR_RE} = 4'h0;
      v = x ? O_XRDATA : O_SFR_RDATA;
    end
  endtask
  task do_reset;
    begin
      @(negedge I_SYS_CLK);
      I_RESETN = 0;
      repeat (6) @(negedge I_SYS_CLK);
      I_RESETN = 1;
      lock = 0;
    end
  endtask
  task burn_fuse(input [7:0] sel, input b);
    begin
      acc(1, 1, `SECURITY_FUSE_OFS, 8'h80);
      acc(1, 1, `FUSE_UNLOCK_KEY_OFS, `KEY_ARM);
      acc(1, 1, `FUSE_UNLOCK_KEY_OFS, sel);
      acc(1, 1, `FUSE_BURN_TRIGGER_OFS, `KEY_BURN);
      for (k = 0; k < 4 && O_FUSE_BURN[b] !== 1'b1; k = k + 1)
        @(negedge I_SYS_CLK);
      chk(O_FUSE_BURN, b ? 8'h02 : 8'h01);
      chk(O_BURN_BUSY, 1);
      I_FUSE_SENSE[b] = 1'b1;
      acc(1, 1, `FUSE_BURN_TRIGGER_OFS, `KEY_CLEAR);
      @(negedge I_SYS_CLK);
      chk(O_FUSE_BURN, 0);
      acc(1, 1, `FUSE_UNLOCK_KEY_OFS, `KEY_CLEAR);
    end
  endtask
  task sweep;
    reg g, q, e;
    integer c;
    begin
      for (c = 0; c < 6; c = c + 1) begin
        r = $random(seed);
        e = !I_FUSE_SENSE[1] && (!(lock && I_FUSE_SENSE[0]) || c == 4);
        i_dbg_port_model.access(c[2:0], r[6:0], g, q);
        chk(g, e);
        chk(q, !e);
        chk(O_XRAM_CLEAR, e && c == 4);
      end
      I_MPU_PAGE = 7'h00;
      I_MPU_PAGE_ERASE = 1;
      #1 chk(O_MPU_REFUSE, lock && I_FUSE_SENSE[0]);
      @(negedge I_SYS_CLK);
      I_MPU_PAGE_ERASE = 0;
      acc(0, 1, `FLASH_CONTROL_OFS, 8'h01);
      I_MPU_FLASH_WR = 1;
      #1 chk(O_MPU_REFUSE, lock && I_FUSE_SENSE[0]);
      chk(O_MPU_GRANT, !(lock && I_FUSE_SENSE[0]));
      @(negedge I_SYS_CLK);
      I_MPU_FLASH_WR = 0;
      chk(O_FLASH_WRITE_SEL, 1);
      I_FLASH_BYTE_DONE = 1;
      @(negedge I_SYS_CLK);
      I_FLASH_BYTE_DONE = 0;
      chk(O_FLASH_WRITE_SEL, 0);
      acc(0, 1, `FLASH_CONTROL_OFS, 8'h02);
      I_MPU_MASS_ERASE = 1;
      #1 chk(O_MPU_GRANT, !I_FUSE_SENSE[1]);
      @(negedge I_SYS_CLK);
      I_MPU_MASS_ERASE = 0;
      chk(O_XRAM_CLEAR, !I_FUSE_SENSE[1]);
    end
  endtask
  initial begin
    r = $random(seed);
    pin = r[0];
    i_dbg_port_model.set_pin(pin);
    do_reset;
    acc(1, 0, `SECURITY_FUSE_OFS, 8'h00);
    chk(v, {2'h0, pin, 5'h00});
    acc(0, 0, `FLASH_CONTROL_OFS, 8'h00);
    chk(v, `FLASH_CONTROL_RST);
    acc(0, 1, `FLASH_CONTROL_OFS, 8'h40);
    lock = 1;
    chk(O_PROTECT_ACTIVE, 0);
    sweep;
    burn_fuse(`KEY_SEL_MODE0, 0);
    chk(O_PROTECT_ACTIVE, 1);
    acc(0, 1, `FLASH_CONTROL_OFS, 8'h00);
    chk(O_PROTECT_ACTIVE, 1);
    acc(1, 0, `SECURITY_FUSE_OFS, 8'h00);
    chk(v, {2'h2, pin, 5'h02});
    sweep;
    do_reset;
    chk(O_PROTECT_ACTIVE, 0);
    sweep;
    i_dbg_port_model.set_pin(1);
    burn_fuse(`KEY_SEL_MODE1, 1);
    chk(O_DBG_ENABLED, 0);
    sweep;
    do_reset;
    chk(O_DBG_ENABLED, 0);
    acc(1, 0, `SECURITY_FUSE_OFS, 8'h00);
    chk(v, 8'h23);
    final_report;
  end
endmodule
